/* File: hw/lie_pkg.sv */
// Package for the line-interface error injector and interrupt-enable slice.
// Assumes a single 200 MHz system clock; line pins arrive asynchronously.
package lie_pkg;

  // Register byte addresses on the Wishbone bus (one 32-bit word each).
  localparam logic [4:0] LIE_ADR_CTL3 = 5'h00;
  localparam logic [4:0] LIE_ADR_IRQ_EN = 5'h04;
  localparam logic [4:0] LIE_ADR_CFG = 5'h08;
  localparam logic [4:0] LIE_ADR_STAT = 5'h0c;
  localparam logic [4:0] LIE_ADR_EVT = 5'h10;

  // Field positions.
  localparam int LIE_INJ_BIT = 1;
  localparam int LIE_DMO_BIT = 6;
  localparam int LIE_FIFO_BIT = 5;
  localparam int LIE_LOOP_BIT = 3;
  localparam int LIE_PAT_LSB = 0;
  localparam int LIE_LMODE_LSB = 4;

  // Writable bit masks and values after reset.
  localparam logic [7:0] LIE_CTL3_RW_MASK = 8'h03;
  localparam logic [7:0] LIE_IRQ_EN_RW_MASK = 8'h6b;
  localparam logic [7:0] LIE_CFG_RW_MASK = 8'h37;
  localparam logic [7:0] LIE_EVT_MASK = 8'h68;
  localparam logic [7:0] LIE_CTL3_RST = 8'h00;
  localparam logic [7:0] LIE_IRQ_EN_RST = 8'h00;
  localparam logic [7:0] LIE_CFG_RST = 8'h00;
  localparam logic [7:0] LIE_EVT_RST = 8'h00;

  // Transmit test-pattern code that selects QRSS generate and detect.
  localparam logic [2:0] LIE_PAT_QRSS = 3'h4;

  // Loop-code detector modes.
  typedef enum logic [1:0] {
    LIE_LM_OFF = 2'h0,
    LIE_LM_UP = 2'h1,
    LIE_LM_DOWN = 2'h2,
    LIE_LM_AUTO = 2'h3
  } lie_lmode_e;

  // Counts in line bit periods; the loop hold is also given in seconds, with the receive rate in Hz.
  localparam int LIE_DMO_QUIET_BITS = 128;
  localparam int LIE_FIFO_MARGIN = 3;
  localparam int LIE_LOOP_HOLD_S = 5;
  localparam int LIE_RX_RATE_HZ = 1544000;
  localparam int LIE_LOOP_HOLD_BITS = LIE_LOOP_HOLD_S * LIE_RX_RATE_HZ;

  // Wishbone classic request from the master.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } lie_wb_req_s;

  // Asynchronous line pins watched by the block.
  typedef struct packed {
    logic tclk;
    logic tx_pos;
    logic tx_neg;
    logic rx_clk;
    logic rx_data;
  } lie_line_pins_s;

endpackage : lie_pkg

/* File: hw/lie_sync.sv */
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes the pins may change at any time relative to clk_i.
`timescale 1ns/100ps
module lie_sync #(
  parameter int W = 1
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Raw and filtered levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_nxt;

  // A bit moves only once stages two and three agree; stage one feeds stage two alone.
  assign q_nxt = (s2_r & s3_r) | (q_o & (s2_r ^ s3_r));

  // Shift chain, frozen with the rest of the block while ce_i is low.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_o <= '0;
    end else if (ce_i) begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_o <= q_nxt;
    end
  end

endmodule : lie_sync

/* File: hw/lie_top.sv */
// Line-interface control slice: single-bit QRSS error injector, driver-monitor
// alarm, jitter FIFO margin flag, loop-code detector and their interrupt enables.
// Assumes a Wishbone classic master on clk_i and asynchronous line pins.
//
// Operation
// - A rising inject bit in QRSS mode flips exactly one transmitted bit.
// - The inject bit is sampled and edge-checked on transmit line clock rises.
// - Control bit 0 and enable bits 7, 4, 2, 1, 0 do nothing; enable bits 7, 4, 2 read zero.
// - Enabled driver-monitor alarm changes, both directions, raise an interrupt.
// - Enable bits are read/write, reset to zero, and gate their sources.
// - Enabled FIFO margin event fires when pointers come within three bits.
// - Enabled loop-code status changes, start and stop, raise an interrupt.
// - Loop status sets after loop-up or loop-down pattern persists over five seconds.
// - Alarm after 128 quiet transmit bits; cleared at once on pulse activity.
`timescale 1ns/100ps
module lie_top #(
  parameter int JA_PTR_W = 5,
  parameter int LOOP_HOLD_BITS = lie_pkg::LIE_LOOP_HOLD_BITS
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone classic slave
  input wire lie_pkg::lie_wb_req_s wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Asynchronous line pins
  input wire lie_pkg::lie_line_pins_s line_i,
  // Same-clock transmit data and jitter attenuator pointers
  input wire logic tx_data_i,
  input wire logic [JA_PTR_W-1:0] ja_wr_ptr_i,
  input wire logic [JA_PTR_W-1:0] ja_rd_ptr_i,
  // Results
  output logic tx_data_o,
  output logic loopback_en_o,
  output logic irq_o
);
  import lie_pkg::*;

  localparam int LC_W = $clog2(LOOP_HOLD_BITS + 2);
  localparam logic [LC_W-1:0] LOOP_LIMIT = LC_W'(LOOP_HOLD_BITS + 1);
  localparam int DQ_W = $clog2(LIE_DMO_QUIET_BITS + 1);
  localparam logic [DQ_W-1:0] DMO_LAST = DQ_W'(LIE_DMO_QUIET_BITS - 1);
  localparam logic [JA_PTR_W-1:0] MARGIN_P = JA_PTR_W'(LIE_FIFO_MARGIN);
  localparam logic [JA_PTR_W-1:0] MARGIN_N = JA_PTR_W'(0) - MARGIN_P;

  // Address match, shared by the write strobes and the read mux.
  function automatic logic lie_hit(input logic [4:0] adr, input logic [4:0] ofs);
    return adr == ofs;
  endfunction : lie_hit

  // A window of one period holding exactly one mark means the pattern repeats.
  function automatic logic lie_loop_match(input logic [3:0] h, input logic b,
                                          input logic long_p);
    logic [4:0] w;
    w = long_p ? {h, b} : {2'b00, h[1:0], b};
    return $onehot(w);
  endfunction : lie_loop_match

  lie_line_pins_s pins_q;
  logic [7:0] ctl3_r;
  logic [7:0] irq_en_r;
  logic [7:0] cfg_r;
  logic [7:0] evt_r;
  logic tclk_d_r;
  logic rx_clk_d_r;
  logic inj_prev_r;
  logic [DQ_W-1:0] quiet_cnt_r;
  logic dmo_r;
  logic margin_r;
  logic [3:0] lsh_r;
  logic [LC_W-1:0] run_cnt_r;
  logic loop_stat_r;

  // Pins pass four flops before anything looks at them.
  lie_sync #(.W($bits(lie_line_pins_s))) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(line_i),
    .q_o(pins_q)
  );

  // Bus decode; the 8-bit registers sit in byte lane 0.
  wire wb_go = ce_i & wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  wire wb_wr = wb_go & wb_req_i.we & wb_req_i.sel[0];
  wire wr_ctl3 = wb_wr & lie_hit(wb_req_i.adr, LIE_ADR_CTL3);
  wire wr_irq_en = wb_wr & lie_hit(wb_req_i.adr, LIE_ADR_IRQ_EN);
  wire wr_cfg = wb_wr & lie_hit(wb_req_i.adr, LIE_ADR_CFG);
  wire wr_evt = wb_wr & lie_hit(wb_req_i.adr, LIE_ADR_EVT);
  wire [7:0] wb_byte = wb_req_i.dat[7:0];

  // Edge ticks of the filtered line clocks, qualified by the clock enable.
  wire tclk_tick = ce_i & pins_q.tclk & ~tclk_d_r;
  wire rx_tick = ce_i & pins_q.rx_clk & ~rx_clk_d_r;

  // Injector: fires once per rise of the control bit seen at a transmit clock edge.
  wire [2:0] pat_sel = cfg_r[LIE_PAT_LSB +: 3];
  wire inj_rise = ctl3_r[LIE_INJ_BIT] & ~inj_prev_r;
  wire inj_fire = tclk_tick & inj_rise & (pat_sel == LIE_PAT_QRSS);

  // Driver monitor: any pulse on either rail counts as bipolar activity.
  wire tx_act = ce_i & (pins_q.tx_pos | pins_q.tx_neg);
  wire dmo_declare = tclk_tick & (quiet_cnt_r == DMO_LAST);
  wire dmo_nxt = tx_act ? 1'b0 : (dmo_declare ? 1'b1 : dmo_r);

  // FIFO margin: pointer distance within the margin in either direction.
  wire [JA_PTR_W-1:0] ja_diff = ja_wr_ptr_i - ja_rd_ptr_i;
  wire margin_nxt = (ja_diff <= MARGIN_P) | (ja_diff >= MARGIN_N);

  // Loop code: loop-down is sought in its own mode, or in auto mode once up was found.
  lie_lmode_e lmode;
  assign lmode = lie_lmode_e'(cfg_r[LIE_LMODE_LSB +: 2]);
  wire seek_down = (lmode == LIE_LM_DOWN) | ((lmode == LIE_LM_AUTO) & loop_stat_r);
  wire rx_match = lie_loop_match(lsh_r, pins_q.rx_data, ~seek_down);
  wire loop_held = (run_cnt_r == LOOP_LIMIT);
  logic loop_stat_nxt;

  // Status follows the hold in plain modes; auto mode toggles on each hold.
  always_comb begin
    case (lmode)
      LIE_LM_UP,
      LIE_LM_DOWN: loop_stat_nxt = loop_held;
      LIE_LM_AUTO: loop_stat_nxt = loop_held ? ~loop_stat_r : loop_stat_r;
      default: loop_stat_nxt = 1'b0;
    endcase
  end

  // Change events, gated by their enables so a cleared enable suppresses the source.
  logic [7:0] evt_set;
  always_comb begin
    evt_set = '0;
    evt_set[LIE_DMO_BIT] = ce_i & irq_en_r[LIE_DMO_BIT] & (dmo_nxt != dmo_r);
    evt_set[LIE_FIFO_BIT] = ce_i & irq_en_r[LIE_FIFO_BIT] & margin_nxt & ~margin_r;
    evt_set[LIE_LOOP_BIT] = ce_i & irq_en_r[LIE_LOOP_BIT]
                            & (loop_stat_nxt != loop_stat_r);
  end
  wire [7:0] evt_clr = wr_evt ? (wb_byte & LIE_EVT_MASK) : 8'h00;
  wire [7:0] evt_nxt = (evt_r & ~evt_clr) | evt_set;

  // Live status byte.
  logic [7:0] stat_byte;
  always_comb begin
    stat_byte = '0;
    stat_byte[LIE_DMO_BIT] = dmo_r;
    stat_byte[LIE_FIFO_BIT] = margin_r;
    stat_byte[LIE_LOOP_BIT] = loop_stat_r;
  end

  // Read mux; an unmapped address answers with zero.
  wire [7:0] rd_byte = lie_hit(wb_req_i.adr, LIE_ADR_CTL3) ? ctl3_r :
                       lie_hit(wb_req_i.adr, LIE_ADR_IRQ_EN) ? irq_en_r :
                       lie_hit(wb_req_i.adr, LIE_ADR_CFG) ? cfg_r :
                       lie_hit(wb_req_i.adr, LIE_ADR_STAT) ? stat_byte :
                       lie_hit(wb_req_i.adr, LIE_ADR_EVT) ? evt_r : 8'h00;

  // Bus slave: one-cycle ack, data registered alongside it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= wb_go;
      wb_dat_o <= wb_go ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Software registers; reserved bits never store, so they read zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl3_r <= LIE_CTL3_RST;
      irq_en_r <= LIE_IRQ_EN_RST;
      cfg_r <= LIE_CFG_RST;
    end else if (ce_i) begin
      if (wr_ctl3) ctl3_r <= wb_byte & LIE_CTL3_RW_MASK;
      if (wr_irq_en) irq_en_r <= wb_byte & LIE_IRQ_EN_RW_MASK;
      if (wr_cfg) cfg_r <= wb_byte & LIE_CFG_RW_MASK;
    end
  end

  // Transmit side: the inject bit is only looked at on transmit clock rises.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tclk_d_r <= 1'b0;
      inj_prev_r <= 1'b0;
      tx_data_o <= 1'b0;
    end else if (ce_i) begin
      tclk_d_r <= pins_q.tclk;
      if (tclk_tick) begin
        inj_prev_r <= ctl3_r[LIE_INJ_BIT];
        tx_data_o <= tx_data_i ^ inj_fire;
      end
    end
  end

  // Driver monitor quiet counter stops while the alarm is up so the alarm cannot retrigger.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      quiet_cnt_r <= '0;
      dmo_r <= 1'b0;
    end else if (ce_i) begin
      dmo_r <= dmo_nxt;
      if (tx_act) quiet_cnt_r <= '0;
      else if (tclk_tick && !dmo_r) quiet_cnt_r <= quiet_cnt_r + DQ_W'(1);
    end
  end

  // Receive loop-code run counter; restarts on a miss, or in auto mode when the target flips.
  // Plain modes let the count saturate, so the status holds while the code keeps arriving.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_clk_d_r <= 1'b0;
      lsh_r <= '0;
      run_cnt_r <= '0;
      loop_stat_r <= 1'b0;
    end else if (ce_i) begin
      rx_clk_d_r <= pins_q.rx_clk;
      loop_stat_r <= loop_stat_nxt;
      if ((lmode == LIE_LM_AUTO && loop_stat_nxt != loop_stat_r) || lmode == LIE_LM_OFF) begin
        run_cnt_r <= '0;
      end else if (rx_tick) begin
        if (!rx_match) run_cnt_r <= '0;
        else if (!loop_held) run_cnt_r <= run_cnt_r + LC_W'(1);
      end
      if (rx_tick) lsh_r <= {lsh_r[2:0], pins_q.rx_data};
    end
  end

  // Events, the combined interrupt and the remote loop-back request.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      margin_r <= 1'b0;
      evt_r <= LIE_EVT_RST;
      irq_o <= 1'b0;
      loopback_en_o <= 1'b0;
    end else if (ce_i) begin
      margin_r <= margin_nxt;
      evt_r <= evt_nxt;
      irq_o <= |(evt_r & irq_en_r & LIE_EVT_MASK);
      loopback_en_o <= (lmode == LIE_LM_AUTO) & loop_stat_r;
    end
  end

  // Checks on the design's own outputs and state.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_inject_flips;
    inj_fire |=> (tx_data_o != $past(tx_data_i));
  endproperty
  a_inject_flips: assert property (p_inject_flips) else $error("inject did not flip");

  property p_no_stray_flip;
    (tclk_tick && !inj_fire) |=> (tx_data_o == $past(tx_data_i));
  endproperty
  a_no_stray_flip: assert property (p_no_stray_flip) else $error("stray bit flip");

  property p_sample_on_tclk;
    !tclk_tick |=> $stable(inj_prev_r);
  endproperty
  a_sample_on_tclk: assert property (p_sample_on_tclk) else $error("inject sampled off edge");

  property p_reserved_zero;
    (wb_ack_o && lie_hit(wb_req_i.adr, LIE_ADR_IRQ_EN))
      |-> (wb_dat_o[7] == 1'b0 && wb_dat_o[4] == 1'b0 && wb_dat_o[2] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read one");

  property p_dmo_event;
    ($changed(dmo_r) && $past(irq_en_r[LIE_DMO_BIT])) |-> evt_r[LIE_DMO_BIT];
  endproperty
  a_dmo_event: assert property (p_dmo_event) else $error("alarm change lost");

  property p_disabled_quiet;
    (!irq_en_r[LIE_DMO_BIT] && !evt_r[LIE_DMO_BIT]) |=> !evt_r[LIE_DMO_BIT];
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled source fired");

  property p_fifo_event;
    ($rose(margin_r) && $past(irq_en_r[LIE_FIFO_BIT])) |-> evt_r[LIE_FIFO_BIT];
  endproperty
  a_fifo_event: assert property (p_fifo_event) else $error("margin event lost");

  property p_loop_event;
    ($changed(loop_stat_r) && $past(irq_en_r[LIE_LOOP_BIT])) |-> evt_r[LIE_LOOP_BIT];
  endproperty
  a_loop_event: assert property (p_loop_event) else $error("loop change lost");

  property p_loop_hold;
    ($rose(loop_stat_r) && lmode != LIE_LM_AUTO) |-> ($past(run_cnt_r) == LOOP_LIMIT);
  endproperty
  a_loop_hold: assert property (p_loop_hold) else $error("loop status early");

  property p_dmo_declare;
    $rose(dmo_r) |-> ($past(quiet_cnt_r) == DMO_LAST && $past(tclk_tick));
  endproperty
  a_dmo_declare: assert property (p_dmo_declare) else $error("alarm declared early");

  property p_dmo_clear;
    tx_act |=> !dmo_r;
  endproperty
  a_dmo_clear: assert property (p_dmo_clear) else $error("alarm not cleared");

  // Any clear this cycle, kept as a net so the check can look two cycles back.
  wire evt_clr_any = |evt_clr;

  property p_irq_merge;
    (ce_i && |(evt_r & irq_en_r & LIE_EVT_MASK))
      |=> irq_o ##1 (irq_o || $past(evt_clr_any, 2) || $past(wr_irq_en, 2));
  endproperty
  a_irq_merge: assert property (p_irq_merge) else $error("interrupt dropped");

  c_inject: cover property (inj_fire);
  c_dmo_rise: cover property ($rose(dmo_r));
  c_loop_rise: cover property ($rose(loop_stat_r));
  c_irq: cover property ($rose(irq_o));
  c_loopback: cover property ($rose(loopback_en_o));

endmodule : lie_top

/* File: test/lie_line_model.sv */
// Far-side line model: transmit line clock, pulse rails, receive clock and data.
// Assumes clk_i is the 200 MHz bench clock; line periods are eight clk cycles.
`timescale 1ns/100ps
module lie_line_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Controls from the bench
  input wire logic tclk_run_i,
  input wire logic pulse_en_i,
  input wire logic [1:0] rx_mode_i,
  // Line pins toward the block
  output lie_pkg::lie_line_pins_s line_o
);
  import lie_pkg::*;
  logic [2:0] ph_r;
  logic [3:0] idx_r;

  // Clocks stand still when stopped; receive data toggles so no stale level is seen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_r <= 3'h0;
      idx_r <= 4'h0;
      line_o <= '0;
    end else begin
      ph_r <= ph_r + 3'h1;
      line_o.tclk <= tclk_run_i & ph_r[2];
      // Marks alternate between the rails, as a bipolar line shows them.
      line_o.tx_pos <= pulse_en_i & (ph_r[2:1] == 2'b10);
      line_o.tx_neg <= pulse_en_i & (ph_r[2:1] == 2'b11);
      line_o.rx_clk <= (rx_mode_i != 2'h0) & ph_r[2];
      if (rx_mode_i == 2'h0) begin
        line_o.rx_data <= ~line_o.rx_data;
      end else if (ph_r == 3'h0) begin
        idx_r <= (idx_r == 4'he) ? 4'h0 : idx_r + 4'h1;
        case (rx_mode_i)
          2'h1: line_o.rx_data <= (idx_r % 5 == 4);
          2'h2: line_o.rx_data <= (idx_r % 3 == 2);
          default: line_o.rx_data <= 1'b1;
        endcase
      end
    end
  end
endmodule : lie_line_model

/* File: test/tb.sv */
// Self-checking bench for the injector and interrupt-enable slice.
// Assumes the line model drives the pins; loop hold shortened to 20 bits.
`timescale 1ns/100ps
module tb;
  import lie_pkg::*;
  logic clk_i, rst_i, tx_data_i, tx_data_o, loopback_en_o, irq_o, wb_ack_o;
  logic ce, tclk_run, pulse_en, prev_r;
  logic [1:0] rx_mode;
  logic [31:0] wb_dat_o;
  logic [4:0] wr_ptr, rd_ptr;
  lie_wb_req_s req;
  lie_line_pins_s line;
  logic [31:0] q[$];
  int mismatches, tests_run, flips, cyc_n, seed, r;

  lie_top #(.LOOP_HOLD_BITS(20)) lie_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_req_i(req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line_i(line),
    .tx_data_i(tx_data_i), .ja_wr_ptr_i(wr_ptr), .ja_rd_ptr_i(rd_ptr),
    .tx_data_o(tx_data_o), .loopback_en_o(loopback_en_o), .irq_o(irq_o));
  lie_line_model lie_line_model_i (.clk_i(clk_i), .rst_i(rst_i), .tclk_run_i(tclk_run),
    .pulse_en_i(pulse_en), .rx_mode_i(rx_mode), .line_o(line));

  // Clock generator, 5 ns period.
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // One classic cycle; the request holds until ack is sampled high.
  // A slave that never answers is caught by the bench timeout.
  task wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask : wb

  task rd(input logic [4:0] a, input logic [7:0] e);
    q.push_back({24'h0, e});
    wb(1'b0, a, 8'h00);
  endtask : rd

  // Waits a bounded time for the interrupt line to reach a level.
  task wt(input logic e, input int b);
    int n;
    n = 0;
    while (irq_o !== e && n < b) begin
      @(posedge clk_i);
      n++;
    end
    chk("irq", irq_o, e);
  endtask : wt

  // Read data is compared with the oldest noted expectation at each read ack.
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && req.we === 1'b0) chk("rdata", wb_dat_o, q.pop_front());
    prev_r <= tx_data_o;
    if (tx_data_o === 1'b1 && prev_r === 1'b0) flips++;
    cyc_n++;
    if (cyc_n == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  // Main sequence of scenarios.
  initial begin
    seed = 8;
    {rst_i, ce, tclk_run, pulse_en, rx_mode, tx_data_i} = {2'b11, 5'h0};
    req = '0;
    r = $random(seed);
    wr_ptr = r[4:0];
    rd_ptr = wr_ptr + 5'ha;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    tclk_run <= 1'b1;
    pulse_en <= 1'b1;
    rd(LIE_ADR_CTL3, 8'h00);
    rd(LIE_ADR_IRQ_EN, 8'h00);
    r = $random(seed);
    wb(1'b1, LIE_ADR_IRQ_EN, r[7:0]);
    rd(LIE_ADR_IRQ_EN, r[7:0] & LIE_IRQ_EN_RW_MASK);
    wb(1'b1, LIE_ADR_IRQ_EN, 8'h00);
    wb(1'b1, LIE_ADR_CTL3, r[15:8]);
    rd(LIE_ADR_CTL3, r[15:8] & LIE_CTL3_RW_MASK);
    rd(5'h14, 8'h00);
    // Three injections in QRSS mode, then one with another pattern selected.
    wb(1'b1, LIE_ADR_CFG, {5'h0, LIE_PAT_QRSS});
    for (int i = 0; i < 4; i++) begin
      if (i == 3) wb(1'b1, LIE_ADR_CFG, 8'h03);
      wb(1'b1, LIE_ADR_CTL3, {7'h0, r[i]});
      repeat (20) @(posedge clk_i);
      wb(1'b1, LIE_ADR_CTL3, {6'h0, 1'b1, r[i]});
      repeat (20) @(posedge clk_i);
    end
    chk("flips", flips, 3);
    // Alarm with its enable cleared must not interrupt.
    pulse_en <= 1'b0;
    repeat (1300) @(posedge clk_i);
    chk("irq_gated", irq_o, 1'b0);
    rd(LIE_ADR_STAT, 8'h40);
    rd(LIE_ADR_EVT, 8'h00);
    wb(1'b1, LIE_ADR_IRQ_EN, 8'h40);
    pulse_en <= 1'b1;
    wt(1'b1, 50);
    repeat (30) @(posedge clk_i);
    chk("irq_held", irq_o, 1'b1);
    rd(LIE_ADR_EVT, 8'h40);
    wb(1'b1, LIE_ADR_EVT, 8'h40);
    wt(1'b0, 5);
    // A low clock enable freezes the quiet count, so no alarm is declared.
    ce <= 1'b0;
    pulse_en <= 1'b0;
    repeat (1300) @(posedge clk_i);
    chk("irq_frozen", irq_o, 1'b0);
    ce <= 1'b1;
    wt(1'b1, 1300);
    wb(1'b1, LIE_ADR_EVT, 8'h40);
    wt(1'b0, 5);
    // Pointer distance four stays quiet, three raises the margin event.
    wb(1'b1, LIE_ADR_IRQ_EN, 8'h20);
    rd_ptr <= wr_ptr - 5'h4;
    repeat (10) @(posedge clk_i);
    chk("irq_far", irq_o, 1'b0);
    rd_ptr <= wr_ptr - 5'h3;
    wt(1'b1, 10);
    rd(LIE_ADR_EVT, 8'h20);
    wb(1'b1, LIE_ADR_EVT, 8'h20);
    wt(1'b0, 5);
    // Loop-up then loop-down: detection start and stop each interrupt.
    wb(1'b1, LIE_ADR_IRQ_EN, 8'h08);
    for (int m = 1; m < 3; m++) begin
      wb(1'b1, LIE_ADR_CFG, {2'h0, m[1:0], 4'h0});
      rx_mode <= m[1:0];
      wt(1'b1, 600);
      rd(LIE_ADR_STAT, 8'h68);
      wb(1'b1, LIE_ADR_EVT, 8'h08);
      wt(1'b0, 5);
      rx_mode <= 2'h3;
      wt(1'b1, 100);
      wb(1'b1, LIE_ADR_EVT, 8'h08);
      wt(1'b0, 5);
    end
    // Auto mode: loop-up holds the loop-back until loop-down has persisted.
    wb(1'b1, LIE_ADR_CFG, 8'h30);
    rx_mode <= 2'h1;
    wt(1'b1, 600);
    chk("loopback_on", loopback_en_o, 1'b1);
    wb(1'b1, LIE_ADR_EVT, 8'h08);
    wt(1'b0, 5);
    rx_mode <= 2'h3;
    repeat (100) @(posedge clk_i);
    chk("loopback_kept", loopback_en_o, 1'b1);
    rd(LIE_ADR_STAT, 8'h68);
    rx_mode <= 2'h2;
    wt(1'b1, 600);
    chk("loopback_off", loopback_en_o, 1'b0);
    wb(1'b1, LIE_ADR_EVT, 8'h08);
    wt(1'b0, 5);
    wrap_up();
  end
endmodule : tb
